//--- shared/tef_map.vh
// Purpose: register map and field positions of the timer event flag block
// Assumes: classic Wishbone slave, 32-bit data, byte addresses
// Notes:   definitions only
`ifndef TEF_MAP_VH
`define TEF_MAP_VH

// register byte offsets
`define TEF_OFS_CONTROL      8'h00
`define TEF_OFS_REQ_ENABLE   8'h0C
`define TEF_OFS_EVT_STATUS   8'h10
`define TEF_OFS_EVT_GEN      8'h14
`define TEF_OFS_CAP1         8'h34
`define TEF_OFS_CAP2         8'h38
`define TEF_OFS_CAP3         8'h3C
`define TEF_OFS_CAP4         8'h40

// reset values
`define TEF_RST_CONTROL      16'h0000
`define TEF_RST_REQ_ENABLE   16'h0000
`define TEF_RST_EVT_STATUS   16'h0000
`define TEF_RST_CAP          16'h0000

// control register fields
`define TEF_CTL_UPD_DISABLE  0
`define TEF_CTL_UPD_SRC_SEL  1
`define TEF_CTL_TSEL_LO      4
`define TEF_CTL_TSEL_HI      6
`define TEF_CTL_CHIN_LO      8
`define TEF_CTL_CHIN_HI      11
`define TEF_CTL_MASK         16'h0F73

// request enable fields
`define TEF_EN_IRQ_LO        0
`define TEF_EN_IRQ_HI        7
`define TEF_EN_DMA_LO        8
`define TEF_EN_DMA_HI        14
`define TEF_EN_MASK          16'h7FFF

// status fields
`define TEF_ST_UPDATE        0
`define TEF_ST_CHAN_LO       1
`define TEF_ST_CHAN_HI       4
`define TEF_ST_PHASE_SWITCH  5
`define TEF_ST_TRIGGER       6
`define TEF_ST_BREAK         7

// event generate field
`define TEF_GEN_UPDATE       0

// trigger select codes
`define TEF_TSEL_TMR5        3'h0
`define TEF_TSEL_TMR2        3'h1
`define TEF_TSEL_TMR3        3'h2
`define TEF_TSEL_TMR4        3'h3

`endif

//--- core/tef_core.v
// Purpose: event flags, request enables and trigger routing of a timer
// Assumes: classic Wishbone slave; event inputs are one-cycle pulses
//          synchronous to clk; break_in is a level
// Notes:   counter, slave controller and output stages live elsewhere
//
// How it works
// - trigger_select codes 0..3 route timers five, two, three, four
// - enable bit 0 gates the update interrupt request
// - enable bits 1..4 gate channel one to four interrupt requests
// - enable bits 5..7 gate phase switch, trigger, break interrupts
// - enable bit 8 gates the update DMA request
// - enable bits 9..12 gate channel one to four DMA requests
// - bits 13, 14 gate phase switch, trigger DMA; bit 15 reads zero
// - status bit 0 set on update event, held until software clears
// - repetition overflow or underflow gives update unless updates disabled
// - update_generate write gives update when source select and disable low
// - trigger reinit gives update when source select and disable low
// - channel one as output sets bit 1 on compare match
// - channel one as input sets bit 1 on capture; write or read clears
// - bits 2..4 act for channels two..four like bit 1
// - status bit 5 set on phase switch event until cleared
// - status bit 6 set on trigger event until cleared
// - status bit 7 set on break, zero when no break occurred
// - break flag held while break input active; clear only afterwards
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "tef_map.vh"

module tef_core (
    // clock, reset, enable
    input  wire        clk,
    input  wire        srst,
    input  wire        ce,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output wire        wb_ack_o,
    // timer core events
    input  wire [15:0] counter_value,
    input  wire        rep_wrap,
    input  wire        trig_reinit,
    input  wire        trigger_event,
    input  wire        phase_switch_event,
    input  wire        break_in,
    input  wire [3:0]  chan_match,
    input  wire [3:0]  chan_capture,
    // internal trigger sources: 0 tmr5, 1 tmr2, 2 tmr3, 3 tmr4
    input  wire [3:0]  internal_trigger_input,
    // outputs to timer core
    output reg         trigger_to_slave,
    output reg         update_event,
    // requests to interrupt and dma controllers
    output wire [7:0]  irq_req,
    output wire [6:0]  dma_req
);

    reg  [15:0] control_r;
    reg  [15:0] control_nxt;
    reg  [15:0] enable_r;
    reg  [15:0] enable_nxt;
    reg  [15:0] status_r;
    reg  [15:0] status_nxt;
    reg  [15:0] cap_r [0:3];
    reg         ack_r;
    reg  [31:0] rdata_nxt;

    wire        acc;
    wire        wr_acc;
    wire        rd_acc;
    wire        upd_dis;
    wire        upd_src;
    wire [2:0]  tsel;
    wire [3:0]  chan_in;
    wire        gen_wr;
    wire        upd_now;
    wire [3:0]  chan_set;
    wire [3:0]  cap_rd;
    wire [15:0] hw_set;
    wire [15:0] sw_clr;

    // byte-lane merge of a write into a 16-bit register
    function [15:0] lane_merge;
        input [15:0] old_v;
        input [31:0] new_v;
        input [3:0]  sel;
        begin
            lane_merge[7:0]  = sel[0] ? new_v[7:0]  : old_v[7:0];
            lane_merge[15:8] = sel[1] ? new_v[15:8] : old_v[15:8];
        end
    endfunction

    // true on the acking edge of a write or read at the given offset
    function hit;
        input       valid;
        input [7:0] adr;
        input [7:0] ofs;
        begin
            hit = valid && (adr == ofs);
        end
    endfunction

    // bus handshake: ack one cycle after the request, then dropped
    assign acc      = wb_cyc_i && wb_stb_i && ack_r;
    assign wr_acc   = acc && wb_we_i;
    assign rd_acc   = acc && !wb_we_i;
    assign wb_ack_o = ack_r;

    always @(posedge clk) begin
        if (srst) begin
            ack_r <= 1'b0;
        end else if (ce) begin
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
        end
    end

    // control fields
    assign upd_dis = control_r[`TEF_CTL_UPD_DISABLE];
    assign upd_src = control_r[`TEF_CTL_UPD_SRC_SEL];
    assign tsel    = control_r[`TEF_CTL_TSEL_HI:`TEF_CTL_TSEL_LO];
    assign chan_in = control_r[`TEF_CTL_CHIN_HI:`TEF_CTL_CHIN_LO];

    always @(posedge clk) begin
        if (srst) begin
            trigger_to_slave <= 1'b0;
        end else if (ce) begin
            case (tsel)
                `TEF_TSEL_TMR5: trigger_to_slave <= internal_trigger_input[0];
                `TEF_TSEL_TMR2: trigger_to_slave <= internal_trigger_input[1];
                `TEF_TSEL_TMR3: trigger_to_slave <= internal_trigger_input[2];
                `TEF_TSEL_TMR4: trigger_to_slave <= internal_trigger_input[3];
                default:        trigger_to_slave <= 1'b0;
            endcase
        end
    end

    // update_generate is a write-only strobe bit
    assign gen_wr = hit(wr_acc, wb_adr_i, `TEF_OFS_EVT_GEN) && wb_sel_i[0]
                    && wb_dat_i[`TEF_GEN_UPDATE];

    assign upd_now = (rep_wrap && !upd_dis)
                   || ((gen_wr || trig_reinit) && !upd_dis && !upd_src);

    always @(posedge clk) begin
        if (srst) begin
            update_event <= 1'b0;
        end else if (ce) begin
            update_event <= upd_now;
        end
    end

    assign chan_set = (chan_match & ~chan_in) | (chan_capture & chan_in);

    // reading a capture register clears its flag
    assign cap_rd[0] = hit(rd_acc, wb_adr_i, `TEF_OFS_CAP1);
    assign cap_rd[1] = hit(rd_acc, wb_adr_i, `TEF_OFS_CAP2);
    assign cap_rd[2] = hit(rd_acc, wb_adr_i, `TEF_OFS_CAP3);
    assign cap_rd[3] = hit(rd_acc, wb_adr_i, `TEF_OFS_CAP4);

    // break flag held while break active
    assign hw_set = {8'h00, break_in, trigger_event, phase_switch_event,
                     chan_set, upd_now};

    // write zero clears, write one keeps
    assign sw_clr[7:0] = (hit(wr_acc, wb_adr_i, `TEF_OFS_EVT_STATUS)
                          && wb_sel_i[0]) ? ~wb_dat_i[7:0] : 8'h00;
    assign sw_clr[15:8] = 8'h00;

    always @* begin
        control_nxt = control_r;
        enable_nxt  = enable_r;
        if (hit(wr_acc, wb_adr_i, `TEF_OFS_CONTROL)) begin
            control_nxt = lane_merge(control_r, wb_dat_i, wb_sel_i)
                          & `TEF_CTL_MASK;
        end
        if (hit(wr_acc, wb_adr_i, `TEF_OFS_REQ_ENABLE)) begin
            enable_nxt = lane_merge(enable_r, wb_dat_i, wb_sel_i)
                         & `TEF_EN_MASK;
        end
        status_nxt = (status_r & ~sw_clr
                      & ~{11'h000, cap_rd, 1'b0}) | hw_set;
    end

    always @(posedge clk) begin
        if (srst) begin
            control_r <= `TEF_RST_CONTROL;
            enable_r  <= `TEF_RST_REQ_ENABLE;
            status_r  <= `TEF_RST_EVT_STATUS;
        end else if (ce) begin
            control_r <= control_nxt;
            enable_r  <= enable_nxt;
            status_r  <= status_nxt;
        end
    end

    // capture registers latch the counter on input capture
    // one process drives the whole array, so each word has one driver
    integer k;
    always @(posedge clk) begin
        for (k = 0; k < 4; k = k + 1) begin
            if (srst) begin
                cap_r[k] <= `TEF_RST_CAP;
            end else if (ce && chan_in[k] && chan_capture[k]) begin
                cap_r[k] <= counter_value;
            end
        end
    end

    // read data, latched at the edge that raises ack
    always @* begin
        rdata_nxt = 32'h0000_0000;
        case (wb_adr_i)
            `TEF_OFS_CONTROL:    rdata_nxt = {16'h0000, control_r};
            `TEF_OFS_REQ_ENABLE: rdata_nxt = {16'h0000, enable_r};
            `TEF_OFS_EVT_STATUS: rdata_nxt = {16'h0000, status_r};
            `TEF_OFS_CAP1:       rdata_nxt = {16'h0000, cap_r[0]};
            `TEF_OFS_CAP2:       rdata_nxt = {16'h0000, cap_r[1]};
            `TEF_OFS_CAP3:       rdata_nxt = {16'h0000, cap_r[2]};
            `TEF_OFS_CAP4:       rdata_nxt = {16'h0000, cap_r[3]};
            default:             rdata_nxt = 32'h0000_0000;
        endcase
    end

    always @(posedge clk) begin
        if (srst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (ce && wb_cyc_i && wb_stb_i && !ack_r) begin
            wb_dat_o <= rdata_nxt;
        end
    end

    assign irq_req = status_r[7:0]
                     & enable_r[`TEF_EN_IRQ_HI:`TEF_EN_IRQ_LO];
    // update, channel, phase switch and trigger dma gates
    assign dma_req = status_r[6:0]
                     & enable_r[`TEF_EN_DMA_HI:`TEF_EN_DMA_LO];

endmodule

//--- dv/tef_req_sink.sv
// Purpose: stand-in for the interrupt and dma controllers
// Assumes: requests are levels
// Notes:   remembers every request line seen high
`timescale 1ns/1ps
module tef_req_sink (
    // clock and clear
    input  wire        clk,
    input  wire        clr,
    // requests
    input  wire [7:0]  irq_req,
    input  wire [6:0]  dma_req,
    output reg  [14:0] seen_r
);
    always @(posedge clk) begin
        seen_r <= clr ? 15'h0000 : seen_r | {dma_req, irq_req};
    end
endmodule

//--- dv/tef_properties.sv
// Purpose: port checks of tef_core
// Assumes: single clock domain
// Notes:   bound below
`timescale 1ns/1ps
module tef_properties (
    // clock
    input wire       clk,
    input wire       srst,
    input wire       ce,
    // bus
    input wire       wb_cyc_i,
    input wire       wb_stb_i,
    input wire       wb_we_i,
    input wire       wb_ack_o,
    // events
    input wire       rep_wrap,
    input wire       trig_reinit,
    input wire       phase_switch_event,
    input wire       break_in,
    input wire [3:0] internal_trigger_input,
    // outputs
    input wire       trigger_to_slave,
    input wire       update_event,
    input wire [7:0] irq_req,
    input wire [6:0] dma_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire acc = wb_cyc_i & wb_stb_i;
    wire wr = acc & wb_we_i;
    property p_ack; acc && !wb_ack_o && ce |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    property p_ack1; wb_ack_o && ce |=> !wb_ack_o; endproperty
    a_ack1: assert property (p_ack1) else $error("ack long");
    property p_rst; disable iff (1'b0)
        srst && ce |=> !wb_ack_o && irq_req == 0 && dma_req == 0; endproperty
    a_rst: assert property (p_rst) else $error("reset");
    property p_hold; !acc && ce |=> ({dma_req, irq_req}
        & $past({dma_req, irq_req})) == $past({dma_req, irq_req}); endproperty
    a_hold: assert property (p_hold) else $error("flag lost");
    property p_upd; update_event && $past(ce)
        |-> $past(rep_wrap | trig_reinit | wr & wb_ack_o); endproperty
    a_upd: assert property (p_upd) else $error("update");
    property p_brk; $rose(irq_req[7]) |-> $past(break_in | wr); endproperty
    a_brk: assert property (p_brk) else $error("break");
    property p_brkh; irq_req[7] && break_in && ce && !wr |=> irq_req[7];
    endproperty
    a_brkh: assert property (p_brkh) else $error("break hold");
    property p_sw; $rose(irq_req[5] | dma_req[5])
        |-> $past(phase_switch_event | wr); endproperty
    a_sw: assert property (p_sw) else $error("switch");
    property p_trg; $rose(trigger_to_slave)
        |-> $past(|internal_trigger_input); endproperty
    a_trg: assert property (p_trg) else $error("route");
endmodule

bind tef_core tef_properties tef_properties_inst (.*);

//--- dv/tef_core_tb_top.sv
// Purpose: register level test of tef_core
// Assumes: ce held high
// Notes:   events driven as one packed vector
`timescale 1ns/1ps
module tef_core_tb_top;
    logic        clk, srst, ce, cyc, stb, we;
    logic [7:0]  adr;
    logic [31:0] dat, q;
    logic [12:0] evt;
    logic [3:0]  itr;
    logic [47:0] tbl [14];
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, trigger_to_slave, update_event;
    wire  [7:0]  irq_req;
    wire  [6:0]  dma_req;
    wire  [14:0] seen_r;
    int          mismatches, comparisons, i, upd_cnt, upd_base;

    // counts update pulses so each table step can check the output
    initial upd_cnt = 0;
    always @(posedge clk) begin
        if (update_event === 1'b1)
            upd_cnt <= upd_cnt + 1;
    end

    tef_core tef_core_inst (
        .clk(clk), .srst(srst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .counter_value(16'h1234),
        .rep_wrap(evt[0]), .trig_reinit(evt[1]), .trigger_event(evt[2]),
        .phase_switch_event(evt[3]), .break_in(evt[4]),
        .chan_match(evt[8:5]), .chan_capture(evt[12:9]),
        .internal_trigger_input(itr), .trigger_to_slave(trigger_to_slave),
        .update_event(update_event), .irq_req(irq_req), .dma_req(dma_req));
    tef_req_sink tef_req_sink_inst (.clk(clk), .clr(srst),
        .irq_req(irq_req), .dma_req(dma_req), .seen_r(seen_r));

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        wb(1'b1, a, {16'h0000, d});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic pulse(input logic [12:0] v);
        evt <= v;
        @(posedge clk);
        evt <= 13'h0000;
        @(posedge clk);
    endtask
    task end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #100000;
        mismatches++;
        end_of_test;
    end
    initial begin
        {srst, ce, cyc, stb, we, adr, dat, evt, itr} = {2'b11, 60'h0};
        mismatches = 0;
        comparisons = 0;
        // control, event vector, expected status
        tbl = '{48'h000000010001, 48'h000100010000, 48'h000200010001,
                48'h000000020001, 48'h000200020000, 48'h000100020000,
                48'h000000000001, 48'h000200000000, 48'h000100000000,
                48'h000000040040, 48'h000000080020, 48'h000001E0001E,
                48'h0F0001E00000, 48'h0F001E00001E};
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(8'h0C, 32'h0);
        rd(8'h10, 32'h0);
        wr(8'h0C, 16'hFFFF);
        rd(8'h0C, 32'h7FFF);
        rd(8'h20, 32'h0);
        pulse(13'h01FD);
        rd(8'h10, 32'hFF);
        for (i = 0; i < 15; i++) begin
            wr(8'h0C, 16'h0001 << i);
            chk({dma_req, irq_req}, 32'h1 << i);
        end
        chk(seen_r, 32'h7FFF);
        wr(8'h0C, 16'h7FFF);
        wr(8'h10, 16'hFFFE);
        rd(8'h10, 32'hFE);
        evt <= 13'h0010;
        wr(8'h10, 16'h0000);
        rd(8'h10, 32'h80);
        evt <= 13'h0000;
        @(posedge clk);
        wr(8'h10, 16'h0000);
        rd(8'h10, 32'h0);
        for (i = 0; i < 14; i++) begin
            wr(8'h00, tbl[i][47:32]);
            wr(8'h10, 16'h0000);
            upd_base = upd_cnt;
            if (tbl[i][31:16] == 16'h0000)
                wr(8'h14, 16'h0001);
            else
                pulse(tbl[i][28:16]);
            rd(8'h10, {16'h0, tbl[i][15:0]});
            chk(upd_cnt - upd_base, {31'h0, tbl[i][0]});
        end
        for (i = 0; i < 4; i++) begin
            rd(8'(8'h34 + 4 * i), 32'h1234);
            rd(8'h10, 32'h1E & ~((32'h4 << i) - 2));
        end
        for (i = 0; i < 4; i++) begin
            wr(8'h00, 16'(i << 4));
            itr <= 4'h1 << i;
            repeat (2) @(posedge clk);
            chk(trigger_to_slave, 32'h1);
            itr <= ~(4'h1 << i);
            repeat (2) @(posedge clk);
            chk(trigger_to_slave, 32'h0);
        end
        end_of_test;
    end
endmodule
